/* logic/oss_defs.vh */
// Purpose: constants for the clock source select and postscaler block
// Assumes: byte addresses on the register bus, 32-bit data
// Notes:   mode codes are defaults of top-level parameters
//
// How it works
// - Three-bit strap picks one of eight modes
// - RC mode drives Fosc/4 on out pin
// - RC io mode frees the out pin
// - Internal mode frees in pin, drives Fosc/4
// - Internal io mode frees both pins
// - External clock mode frees the out pin
// - Three crystal modes, each own amplifier gain
// - Eight internal frequencies, 16 MHz maximum
// - Postscaler divides internal base by 1/2/4/8
// - Fast strap picks 16 MHz else 500 kHz
// - Sets 16/8/4/2 MHz or 500/250/125/62.5 kHz
// - Any reset loads frequency select with 10
// - New frequency select acts without delay
// - Codes 11/10/01/00 divide by 1/2/4/8
// - Crystal modes hold execution for 1024 cycles
// - External clock mode skips the start-up count
`ifndef OSS_DEFS_VH
`define OSS_DEFS_VH

// Register byte addresses
`define OSS_ADDR_CTRL   4'h0
`define OSS_ADDR_STAT   4'h4

// Control register fields
`define OSS_IFS_HI      5
`define OSS_IFS_LO      4
`define OSS_IFS_RST     2'h2

// Status register fields
`define OSS_ST_MODE_HI  2
`define OSS_ST_MODE_LO  0
`define OSS_ST_FAST     3
`define OSS_ST_HOLD     4
`define OSS_ST_FREE_IN  5
`define OSS_ST_FREE_OUT 6

// Default mode codes
`define OSS_M_RC        3'h0
`define OSS_M_RESISTOR_CAP_IO_MODE      3'h1
`define OSS_M_INT       3'h2
`define OSS_M_INTIO     3'h3
`define OSS_M_EXT       3'h4
`define OSS_M_HS        3'h5
`define OSS_M_XT        3'h6
`define OSS_M_LP        3'h7

// Amplifier gain codes
`define OSS_GAIN_LOW    2'h1
`define OSS_GAIN_MED    2'h2
`define OSS_GAIN_HIGH   2'h3

// Start-up count in oscillator cycles
`define OSS_OST_LAST    11'h3FF

`endif

/* logic/oss_edge_sync.v */
// Purpose: bring a raw oscillator level into the system clock domain
// Assumes: input toggles slower than half the system clock
// Notes:   second stage feeds the edge detector, first stage nothing else
module oss_edge_sync (
    input  wire i_sys_clk,
    input  wire i_rst_n,
    input  wire i_raw,
    output wire o_level,
    output wire o_rise
);

    reg meta_ff;    // First stage, read only by stage two
    reg sync_ff;    // Second stage
    reg prev_ff;    // Delayed copy for edge detect

    ////////////////////////////////////////////////////////////////
    // Two-stage synchroniser plus history; reset to high so a
    // source already high at release gives no false rise
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            prev_ff <= 1'b1;
        end else begin
            meta_ff <= i_raw;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // Rising edge, one cycle wide
    assign o_level = sync_ff;
    assign o_rise  = sync_ff & ~prev_ff;

endmodule

/* logic/oss_top.v */
// Purpose: clock source select, internal postscaler, start-up hold
// Assumes: oscillators are sampled by i_sys_clk, so each must run
//          below half of 20 MHz in simulation
// Notes:   the system clock is modelled as a one-cycle tick
//
// Design decisions made here: register access over Avalon-MM and the address map.
`include "oss_defs.vh"

module oss_top #(
    parameter [2:0] MODE_RC    = `OSS_M_RC,
    parameter [2:0] MODE_RESISTOR_CAP_IO_MODE  = `OSS_M_RESISTOR_CAP_IO_MODE,
    parameter [2:0] MODE_INT   = `OSS_M_INT,
    parameter [2:0] MODE_INTIO = `OSS_M_INTIO,
    parameter [2:0] MODE_EXT   = `OSS_M_EXT,
    parameter [2:0] MODE_HS    = `OSS_M_HS,
    parameter [2:0] MODE_XT    = `OSS_M_XT,
    parameter [2:0] MODE_LP    = `OSS_M_LP
) (
    input  wire        i_sys_clk,
    input  wire        i_rst_n,
    // Configuration word straps
    input  wire [2:0]  i_clock_mode_select,
    input  wire        i_fast_int_osc_enable,
    // Wake-up from sleep, one-cycle pulse
    input  wire        i_wake,
    // Oscillator signals
    input  wire        i_osc_in_pin,
    input  wire        i_int_osc_fast,
    input  wire        i_int_osc_slow,
    // Avalon-MM slave
    input  wire [3:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    input  wire [3:0]  i_avs_byteenable,
    output reg  [31:0] o_avs_readdata,
    output reg         o_avs_waitrequest,
    // Clock and pin control
    output reg         o_sys_tick,
    output reg         o_exec_hold,
    output reg         o_osc_out_o,
    output reg         o_osc_out_oe,
    output reg         o_osc_in_free,
    output reg         o_osc_out_free,
    output reg         o_xtal_amp_en,
    output reg  [1:0]  o_xtal_gain
);

    ////////////////////////////////////////////////////////////////
    // Declarations

    reg  [2:0]  mode_ff;        // Strapped clock mode
    reg         fast_ff;        // Strapped base select
    reg  [1:0]  ifs_ff;         // Frequency select field
    reg  [1:0]  nxt_ifs;
    reg  [2:0]  ps_cnt_ff;      // Postscaler counter
    reg  [1:0]  q_cnt_ff;       // Fosc/4 phase counter
    reg  [10:0] ost_cnt_ff;     // Start-up counter
    reg  [31:0] nxt_rdata;
    reg  [2:0]  ps_mask;        // Postscaler terminal mask

    wire        in_rise;        // Edge on the in pin
    wire        fast_rise;      // Edge of fast base
    wire        slow_rise;      // Edge of slow base
    wire        base_rise;      // Selected internal base edge
    wire        int_tick;       // Postscaled internal tick
    wire        src_tick;       // Fosc tick of chosen source
    wire        is_rc;
    wire        is_int;
    wire        is_xtal;
    wire        req;            // Any bus request
    wire        take;           // Request answered this edge
    wire        hit_ctrl;
    wire        hit_stat;

    ////////////////////////////////////////////////////////////////
    // Pin and oscillator synchronisers

    // In pin carries RC, external clock or crystal
    oss_edge_sync u_sync_in (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_raw     (i_osc_in_pin),
        .o_level   (),
        .o_rise    (in_rise)
    );

    // 16 MHz base (scaled down in simulation)
    oss_edge_sync u_sync_fast (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_raw     (i_int_osc_fast),
        .o_level   (),
        .o_rise    (fast_rise)
    );

    // 500 kHz base
    oss_edge_sync u_sync_slow (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_raw     (i_int_osc_slow),
        .o_level   (),
        .o_rise    (slow_rise)
    );

    ////////////////////////////////////////////////////////////////
    // Strap capture

    // Straps are caught while reset is held, then frozen
    // so software never alters them
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            mode_ff <= i_clock_mode_select;
            fast_ff <= i_fast_int_osc_enable;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Mode decode

    // Group the eight codes by source kind
    assign is_rc   = (mode_ff == MODE_RC) |
                     (mode_ff == MODE_RESISTOR_CAP_IO_MODE);
    assign is_int  = (mode_ff == MODE_INT) |
                     (mode_ff == MODE_INTIO);
    assign is_xtal = (mode_ff == MODE_HS) |
                     (mode_ff == MODE_XT) |
                     (mode_ff == MODE_LP);

    ////////////////////////////////////////////////////////////////
    // Internal base and postscaler

    // Base pick follows the fast strap
    assign base_rise = fast_ff ? fast_rise : slow_rise;

    // Divide ratio from the select field
    always @* begin
        case (ifs_ff)
            2'h3:    ps_mask = 3'h0;    // Divide by 1
            2'h2:    ps_mask = 3'h1;    // Divide by 2
            2'h1:    ps_mask = 3'h3;    // Divide by 4
            default: ps_mask = 3'h7;    // Divide by 8
        endcase
    end

    // Free-running counter; the mask is applied live, so a
    // new ratio acts on the very next base edge, no restart
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ps_cnt_ff <= 3'h0;
        end else if (base_rise) begin
            ps_cnt_ff <= ps_cnt_ff + 3'h1;
        end
    end

    // Tick when the masked count is at its top
    assign int_tick = base_rise &
                      ((ps_cnt_ff & ps_mask) == ps_mask);

    // Fosc: internal postscaled, otherwise the in pin
    assign src_tick = is_int ? int_tick : in_rise;

    ////////////////////////////////////////////////////////////////
    // System tick output

    // One-cycle pulse per Fosc period
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_sys_tick <= 1'b0;
        end else begin
            o_sys_tick <= src_tick;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Fosc/4 clock out

    // Toggle every second Fosc tick, period of four
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            q_cnt_ff    <= 2'h0;
            o_osc_out_o <= 1'b0;
        end else if (src_tick) begin
            q_cnt_ff <= q_cnt_ff + 2'h1;
            if (q_cnt_ff[0]) begin
                o_osc_out_o <= ~o_osc_out_o;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Pin ownership and amplifier gain

    // Out pin driven only in the two clock-out modes;
    // crystal modes leave it to the analogue amplifier
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_osc_out_oe   <= 1'b0;
            o_osc_in_free  <= 1'b0;
            o_osc_out_free <= 1'b0;
            o_xtal_amp_en  <= 1'b0;
            o_xtal_gain    <= 2'h0;
        end else begin
            // Clock out in RC and internal modes
            o_osc_out_oe <= (mode_ff == MODE_RC) |
                            (mode_ff == MODE_INT);
            // In pin free only when the internal osc runs
            o_osc_in_free <= is_int;
            // Out pin free in the io-style modes
            o_osc_out_free <= (mode_ff == MODE_RESISTOR_CAP_IO_MODE) |
                              (mode_ff == MODE_INTIO) |
                              (mode_ff == MODE_EXT);
            o_xtal_amp_en <= is_xtal;
            // Gain follows crystal mode
            if (mode_ff == MODE_HS) begin
                o_xtal_gain <= `OSS_GAIN_HIGH;
            end else if (mode_ff == MODE_XT) begin
                o_xtal_gain <= `OSS_GAIN_MED;
            end else if (mode_ff == MODE_LP) begin
                o_xtal_gain <= `OSS_GAIN_LOW;
            end else begin
                o_xtal_gain <= 2'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Start-up hold

    // Crystal modes count 1024 in-pin cycles after reset or
    // wake; other modes release on the next clock. A dead
    // crystal holds forever, which is the intent.
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ost_cnt_ff  <= 11'h000;
            o_exec_hold <= 1'b1;
        end else if (i_wake) begin
            // Restart on wake from sleep
            ost_cnt_ff  <= 11'h000;
            o_exec_hold <= 1'b1;
        end else if (!is_xtal) begin
            // No start-up count outside crystal modes
            o_exec_hold <= 1'b0;
        end else if (o_exec_hold && in_rise) begin
            ost_cnt_ff <= ost_cnt_ff + 11'h001;
            if (ost_cnt_ff == `OSS_OST_LAST) begin
                o_exec_hold <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Bus decode

    assign req      = i_avs_read | i_avs_write;
    // Answer in the cycle waitrequest is low
    assign take     = req & ~o_avs_waitrequest;
    assign hit_ctrl = (i_avs_address == `OSS_ADDR_CTRL);
    assign hit_stat = (i_avs_address == `OSS_ADDR_STAT);

    ////////////////////////////////////////////////////////////////
    // Frequency select register

    // Byte lane 0 holds the field; status is read only
    always @* begin
        nxt_ifs = ifs_ff;
        if (take && i_avs_write && hit_ctrl &&
            i_avs_byteenable[0]) begin
            nxt_ifs = i_avs_writedata[`OSS_IFS_HI:`OSS_IFS_LO];
        end
    end

    // Every reset reloads divide by 2
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ifs_ff <= `OSS_IFS_RST;
        end else begin
            ifs_ff <= nxt_ifs;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read data

    // Unmapped addresses read as zero
    always @* begin
        nxt_rdata = 32'h0000_0000;
        if (hit_ctrl) begin
            nxt_rdata[`OSS_IFS_HI:`OSS_IFS_LO] = ifs_ff;
        end else if (hit_stat) begin
            nxt_rdata[`OSS_ST_MODE_HI:`OSS_ST_MODE_LO] = mode_ff;
            nxt_rdata[`OSS_ST_FAST]     = fast_ff;
            nxt_rdata[`OSS_ST_HOLD]     = o_exec_hold;
            nxt_rdata[`OSS_ST_FREE_IN]  = o_osc_in_free;
            nxt_rdata[`OSS_ST_FREE_OUT] = o_osc_out_free;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Waitrequest and read data registers

    // One wait cycle per access keeps readdata registered;
    // costs a cycle but the bus is rarely used
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h0000_0000;
        end else begin
            o_avs_waitrequest <= ~(req & o_avs_waitrequest);
            if (i_avs_read && o_avs_waitrequest) begin
                o_avs_readdata <= nxt_rdata;
            end
        end
    end

endmodule

/* verif/oss_top_assertions.sv */
// Purpose: port checks on the clock source select block
// Assumes: default mode codes; straps change only under reset
// Notes:   start-up count uses raw in-pin rises, so +/-1 slack
`include "oss_defs.vh"
////////////////////////////////////////////////////////////////////////
module oss_checker (
    input wire        i_sys_clk,
    input wire        i_rst_n,
    input wire [2:0]  i_clock_mode_select,
    input wire        i_fast_int_osc_enable,
    input wire        i_wake,
    input wire        i_osc_in_pin,
    input wire [3:0]  i_avs_address,
    input wire        i_avs_read,
    input wire        i_avs_write,
    input wire [31:0] o_avs_readdata,
    input wire        o_avs_waitrequest,
    input wire        o_sys_tick,
    input wire        o_exec_hold,
    input wire        o_osc_out_oe,
    input wire        o_osc_in_free,
    input wire        o_osc_out_free,
    input wire        o_xtal_amp_en,
    input wire [1:0]  o_xtal_gain
);
    logic [2:0]  mode_ff;  // Strap copy
    logic        fast_ff;  // Base strap copy
    logic        rdy_ff;   // High from one cycle past release
    logic        pin_ff;   // Last in-pin level
    logic [10:0] edge_ff;  // Raw in-pin rises since reset or wake
    wire         xtal = mode_ff >= `OSS_M_HS;
    // Shadow straps and count in-pin rises
    always @(posedge i_sys_clk) begin
        rdy_ff <= i_rst_n;
        pin_ff <= i_osc_in_pin;
        if (!i_rst_n) begin
            mode_ff <= i_clock_mode_select;
            fast_ff <= i_fast_int_osc_enable;
        end
        // Wake restarts the count, like a reset
        if (!i_rst_n || i_wake)
            edge_ff <= 11'h000;
        else if (i_osc_in_pin && !pin_ff)
            edge_ff <= edge_ff + 11'h001;
    end
    ////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    chk_out_drive: assert property (rdy_ff |->
        o_osc_out_oe == (mode_ff == `OSS_M_RC || mode_ff == `OSS_M_INT))
        else $error("out pin drive wrong for mode");
    chk_in_free: assert property (rdy_ff |->
        o_osc_in_free == (mode_ff == `OSS_M_INT || mode_ff == `OSS_M_INTIO))
        else $error("in pin release wrong for mode");
    chk_out_free: assert property (rdy_ff |->
        o_osc_out_free == (mode_ff == `OSS_M_RESISTOR_CAP_IO_MODE ||
        mode_ff == `OSS_M_INTIO || mode_ff == `OSS_M_EXT))
        else $error("out pin release wrong for mode");
    chk_amp_gain: assert property (rdy_ff |-> o_xtal_amp_en == xtal &&
        o_xtal_gain == (mode_ff == `OSS_M_HS ? `OSS_GAIN_HIGH :
        mode_ff == `OSS_M_XT ? `OSS_GAIN_MED :
        mode_ff == `OSS_M_LP ? `OSS_GAIN_LOW : 2'h0))
        else $error("amplifier gain wrong for mode");
    chk_hold_nocount: assert property (rdy_ff && !xtal |->
        o_exec_hold == $past(i_wake))
        else $error("hold outside start-up count");
    chk_ost_count: assert property (xtal && $fell(o_exec_hold) |->
        edge_ff inside {[11'h3FF:11'h401]})
        else $error("start-up hold released at wrong count");
    chk_wake_hold: assert property (i_wake |=> o_exec_hold)
        else $error("wake did not hold execution");
    chk_bus_ack: assert property ((i_avs_read || i_avs_write) &&
        o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("bus answer timing wrong");
    chk_bus_idle: assert property (!(i_avs_read || i_avs_write) |->
        o_avs_waitrequest)
        else $error("waitrequest low while idle");
    chk_status_rd: assert property (i_avs_read && !o_avs_waitrequest &&
        i_avs_address == `OSS_ADDR_STAT |-> {o_avs_readdata[6:5],
        o_avs_readdata[3:0]} == {o_osc_out_free, o_osc_in_free,
        fast_ff, mode_ff})
        else $error("status word does not match straps");
    cover property (xtal && $fell(o_exec_hold));
    cover property (i_avs_write && !o_avs_waitrequest);
    cover property (i_wake);
    cover property (o_sys_tick);
endmodule
bind oss_top oss_checker chk_u (.i_sys_clk, .i_rst_n, .i_clock_mode_select,
    .i_fast_int_osc_enable, .i_wake, .i_osc_in_pin, .i_avs_address,
    .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest,
    .o_sys_tick, .o_exec_hold, .o_osc_out_oe, .o_osc_in_free,
    .o_osc_out_free, .o_xtal_amp_en, .o_xtal_gain);

/* verif/oss_top_tb_top.sv */
// Purpose: directed bench for the clock source select block
// Assumes: internal oscillators at 1/4 and 1/8 of the bus clock
// Notes:   in-pin runs at 1/6 of the bus clock in every mode
`include "oss_defs.vh"
////////////////////////////////////////////////////////////////////////
module oss_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_sys_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [2:0]  i_clock_mode_select = 3'h0;
    logic        i_fast_int_osc_enable = 1'b0;
    logic        i_wake = 1'b0;
    logic        i_osc_in_pin = 1'b0;
    logic        i_int_osc_fast = 1'b0;
    logic        i_int_osc_slow = 1'b0;
    logic [3:0]  i_avs_address = 4'h0;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0]  i_avs_byteenable = 4'hF;
    wire  [31:0] o_avs_readdata;
    wire         o_avs_waitrequest, o_sys_tick, o_exec_hold;
    wire         o_osc_out_o, o_osc_out_oe, o_osc_in_free;
    wire         o_osc_out_free, o_xtal_amp_en;
    wire  [1:0]  o_xtal_gain;
    logic [31:0] rdata;           // Last word read
    logic [2:0]  div_ff = 3'h0;   // Oscillator divider
    int          p_cnt = 0;       // In-pin divider
    int          err_total = 0;
    int          check_count = 0;
    int          c;
    initial forever #25 i_sys_clk = ~i_sys_clk;
    // Free-running sources; a crystal would not stop either
    always @(posedge i_sys_clk) begin
        div_ff <= div_ff + 3'h1;
        p_cnt <= (p_cnt == 2) ? 0 : p_cnt + 1;
        if (div_ff[0])
            i_int_osc_fast <= ~i_int_osc_fast;
        if (div_ff[1:0] == 2'h3)
            i_int_osc_slow <= ~i_int_osc_slow;
        if (p_cnt == 2)
            i_osc_in_pin <= ~i_osc_in_pin;
    end
    oss_top dut_u (.i_sys_clk, .i_rst_n, .i_clock_mode_select,
        .i_fast_int_osc_enable, .i_wake, .i_osc_in_pin, .i_int_osc_fast,
        .i_int_osc_slow, .i_avs_address, .i_avs_read, .i_avs_write,
        .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
        .o_avs_waitrequest, .o_sys_tick, .o_exec_hold, .o_osc_out_o,
        .o_osc_out_oe, .o_osc_in_free, .o_osc_out_free, .o_xtal_amp_en,
        .o_xtal_gain);
    ////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Limit ran out: count it and stop
    task automatic hang(input int n);
        if (n >= 8000) begin
            chk("wait limit", 32'h0, 32'h1);
            close_out();
        end
    endtask
    // Straps only move under reset, as programming would fix them
    task automatic rst(input logic [2:0] m, input logic f);
        i_rst_n <= 1'b0;
        i_clock_mode_select <= m;
        i_fast_int_osc_enable <= f;
        repeat (3) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
    endtask
    // One bus access; held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_byteenable <= b;
        i_avs_write <= w;
        i_avs_read <= !w;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 8000);
        hang(n);
        rdata = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    // Cycles between two system ticks
    task automatic per(output int p);
        int n;
        n = 0;
        while (o_sys_tick !== 1'b1 && n < 8000) begin
            @(posedge i_sys_clk);
            n++;
        end
        @(posedge i_sys_clk);
        p = 1;
        while (o_sys_tick !== 1'b1 && p < 8000) begin
            @(posedge i_sys_clk);
            p++;
        end
        hang(n);
        hang(p);
    endtask
    // Cycles until the clock-out level changes
    task automatic half(output int p);
        logic v;
        v = o_osc_out_o;
        p = 0;
        while (o_osc_out_o === v && p < 8000) begin
            @(posedge i_sys_clk);
            p++;
        end
        hang(p);
    endtask
    // Wake pulse; hold must show on the next cycle
    task automatic wake_hold;
        i_wake <= 1'b1;
        @(posedge i_sys_clk);
        i_wake <= 1'b0;
        @(posedge i_sys_clk);
        chk("wake hold", o_exec_hold, 1'b1);
    endtask
    // Hold length in crystal mode: 1024 pin periods of 6 cycles
    task automatic osc_startup_timer;
        int n;
        n = 0;
        while (o_exec_hold === 1'b1 && n < 8000) begin
            @(posedge i_sys_clk);
            n++;
        end
        chk("start-up", n inside {[6120:6160]}, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [6:0] e;
        // Every mode: pin roles, status word, reset select value
        for (int m = 0; m < 8; m++) begin
            rst(m[2:0], m[0]);
            e = {m == 1 || m == 3 || m == 4, m == 2 || m == 3, m >= 5,
                 m[0], m[2:0]};
            chk("pins", {o_osc_out_oe, o_osc_out_free, o_osc_in_free,
                o_exec_hold, o_xtal_amp_en, o_xtal_gain}, {m == 0 ||
                m == 2, e[6:4], m >= 5, m == 5 ? 2'h3 : m == 6 ? 2'h2 :
                m == 7 ? 2'h1 : 2'h0});
            bus(1'b0, `OSS_ADDR_STAT, 32'h0, 4'hF);
            chk("status", rdata, {25'h0, e});
            bus(1'b0, `OSS_ADDR_CTRL, 32'h0, 4'hF);
            chk("ctrl reset", rdata, 32'h20);
        end
        // Refused writes: lane off, read-only, unmapped
        rst(`OSS_M_INT, 1'b1);
        bus(1'b1, `OSS_ADDR_CTRL, 32'h30, 4'h0);
        bus(1'b1, `OSS_ADDR_STAT, 32'h7F, 4'hF);
        bus(1'b1, 4'h8, 32'hFF, 4'hF);
        bus(1'b0, 4'h8, 32'h0, 4'hF);
        chk("unmapped", rdata, 32'h0);
        bus(1'b0, `OSS_ADDR_CTRL, 32'h0, 4'hF);
        chk("ctrl kept", rdata, 32'h20);
        bus(1'b0, `OSS_ADDR_STAT, 32'h0, 4'hF);
        chk("status kept", rdata, 32'h2A);
        // Postscaler on both bases, every select code
        for (int f = 1; f >= 0; f--) begin
            rst(`OSS_M_INT, f[0]);
            for (int s = 3; s >= 0; s--) begin
                bus(1'b1, `OSS_ADDR_CTRL, {26'h0, s[1:0], 4'h0}, 4'hF);
                bus(1'b0, `OSS_ADDR_CTRL, 32'h0, 4'hF);
                chk("ctrl", rdata, {26'h0, s[1:0], 4'h0});
                per(c);
                chk("tick", c, (f ? 4 : 8) << (3 - s));
            end
            half(c);
            half(c);
            chk("clkout", c, (f ? 4 : 8) * 16);
        end
        // RC source: tick per pin period, clock-out at a quarter
        rst(`OSS_M_RC, 1'b0);
        per(c);
        chk("rc tick", c, 6);
        half(c);
        half(c);
        chk("rc clkout", c, 12);
        // External clock: no start-up count after wake
        rst(`OSS_M_EXT, 1'b0);
        per(c);
        chk("ext tick", c, 6);
        wake_hold();
        @(posedge i_sys_clk);
        chk("ext release", o_exec_hold, 1'b0);
        // Crystal: count after reset and again after wake
        rst(`OSS_M_HS, 1'b1);
        osc_startup_timer();
        wake_hold();
        osc_startup_timer();
        close_out();
    end
endmodule
